// ===== src/lesl_pkg.sv
// Shared constants, types and register map of the laser enable sequencer
package lesl_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned REF_CLK_HZ = 250_000_000;
	localparam int unsigned INHIBIT_TIME_MS = 5000;
	localparam longint unsigned INHIBIT_CYCLES_L =
		(64'(INHIBIT_TIME_MS) * 64'(REF_CLK_HZ)) / 64'd1000;
	localparam logic [31:0] INHIBIT_CYCLES = 32'(INHIBIT_CYCLES_L);
	localparam int unsigned SYNC_STAGES = 3;
	localparam logic [2:0] STRAP_WAIT = 3'h4;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h10;

	localparam int unsigned CTRL_INHIBIT_BIT = 0;
	localparam logic CTRL_INHIBIT_RST = 1'b0;
	localparam logic [4:0] IRQ_EN_RST = 5'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// Interrupt event bit positions
	localparam int unsigned EV_OVERHEAT = 0;
	localparam int unsigned EV_ILK_FAULT = 1;
	localparam int unsigned EV_ENABLED = 2;
	localparam int unsigned EV_LASE_OK = 3;
	localparam int unsigned EV_DISABLED = 4;
	localparam int unsigned EV_COUNT = 5;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic oem_strap;
		logic key_strap;
		logic interlock;
		logic gate_req;
		logic start_req;
		logic gate_sw_open;
		logic key_on;
		logic over_temp;
		logic pwm;
	} lesl_pins_s;

	localparam int unsigned PIN_W = $bits(lesl_pins_s);

	typedef struct packed {
		logic key_strap;
		logic oem_strap;
		logic armed;
		logic inhibit;
		logic rf_power;
		logic ilk_fault;
		logic gate_open;
		logic enabled;
		logic overheat;
		logic lasing;
	} lesl_stat_s;

	localparam int unsigned STAT_W = $bits(lesl_stat_s);

endpackage

// ===== src/lesl_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module lesl_sync
	import lesl_pkg::*;
#(
	parameter int unsigned WIDTH = 1
)
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	// ------------------------------------------------------------
	// Stages
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end
		else
		begin
			meta_r <= i_async;
			s2_r <= meta_r;
			s3_r <= s2_r;
		end
	end

	// A change counts once stage two and three agree
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			o_sync <= '0;
		else
			for (int i = 0; i < WIDTH; i++)
				if (s2_r[i] == s3_r[i])
					o_sync[i] <= s3_r[i];
	end

endmodule

// ===== src/lesl_timer.sv
// Restartable inhibit interval counter
`timescale 1ns/1ns
module lesl_timer
	import lesl_pkg::*;
#(
	parameter logic [31:0] CYCLES = INHIBIT_CYCLES
)
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_restart,
	output logic o_busy,
	output logic o_expired
);

	logic [31:0] count_r;

	// ------------------------------------------------------------
	// Countdown
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			count_r <= 32'h0000_0000;
			o_expired <= 1'b0;
		end
		else
		begin
			o_expired <= 1'b0;
			if (i_restart)
				count_r <= CYCLES;
			else if (count_r != 32'h0000_0000)
			begin
				count_r <= count_r - 32'h0000_0001;
				if (count_r == 32'h0000_0001)
					o_expired <= 1'b1;
			end
		end
	end

	assign o_busy = (count_r != 32'h0000_0000);

endmodule

// ===== src/lesl_top.sv
// Laser enable and status sequencer with Avalon-MM register slave
`timescale 1ns/1ns

module lesl_top
	import lesl_pkg::*;
#(
	parameter logic [31:0] INHIBIT_CYC = INHIBIT_CYCLES
)
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_interlock,
	input wire logic i_gate_req,
	input wire logic i_start_req,
	input wire logic i_gate_sw_open,
	input wire logic i_key_on,
	input wire logic i_over_temp,
	input wire logic i_pwm,
	input wire logic i_oem_strap,
	input wire logic i_key_strap,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_lasing,
	output logic o_overheat,
	output logic o_enabled,
	output logic o_gate_open,
	output logic o_ilk_fault,
	output logic o_rf_power,
	output logic o_rf_pwm,
	output logic o_irq
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	lesl_pins_s pins_raw;
	lesl_pins_s pins;
	lesl_pins_s pins_d_r;
	lesl_stat_s stat;

	logic [2:0] strap_cnt_r;
	logic straps_ok_r;
	logic oem_r;
	logic key_fit_r;

	logic ovt_r;
	logic armed_r;
	logic armed_nxt;
	logic start_eff;
	logic key_ok;
	logic enabled_c;
	logic gate_c;
	logic rf_c;
	logic enabled_d_r;
	logic gate_d_r;
	logic ilk_d_r;
	logic lase_ok_d_r;

	logic start_rel;
	logic key_rise;
	logic restart;
	logic busy;
	logic expired;
	logic lase_ok;

	logic sw_inhibit_r;
	logic [EV_COUNT-1:0] irq_stat_r;
	logic [EV_COUNT-1:0] irq_en_r;
	logic [EV_COUNT-1:0] events;
	logic [EV_COUNT-1:0] irq_clr;
	logic ack_r;
	logic req;
	logic wr_go;
	logic [31:0] rd_nxt;

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	assign pins_raw.oem_strap = i_oem_strap;
	assign pins_raw.key_strap = i_key_strap;
	assign pins_raw.interlock = i_interlock;
	assign pins_raw.gate_req = i_gate_req;
	assign pins_raw.start_req = i_start_req;
	assign pins_raw.gate_sw_open = i_gate_sw_open;
	assign pins_raw.key_on = i_key_on;
	assign pins_raw.over_temp = i_over_temp;
	assign pins_raw.pwm = i_pwm;

	lesl_sync #(
		.WIDTH(PIN_W)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_async(pins_raw),
		.o_sync(pins)
	);

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			pins_d_r <= '0;
		else
			pins_d_r <= pins;
	end

	// ------------------------------------------------------------
	// Strap capture after reset release
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			strap_cnt_r <= 3'h0;
			straps_ok_r <= 1'b0;
			oem_r <= 1'b0;
			key_fit_r <= 1'b0;
		end
		else if (!straps_ok_r)
		begin
			strap_cnt_r <= strap_cnt_r + 3'h1;
			if (strap_cnt_r == STRAP_WAIT)
			begin
				straps_ok_r <= 1'b1;
				oem_r <= pins.oem_strap;
				key_fit_r <= pins.key_strap;
			end
		end
	end

	// ------------------------------------------------------------
	// Over-temperature latch
	// ------------------------------------------------------------
	// latch until reset
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			ovt_r <= 1'b0;
		else if (pins.over_temp)
			ovt_r <= 1'b1;
	end

	// ------------------------------------------------------------
	// Arming: power-up, interlock latch and restart toggles
	// ------------------------------------------------------------
	// start ignored with key off when a key is fitted, except in OEM mode
	assign start_eff = pins.start_req && (oem_r || !key_fit_r || pins.key_on);
	assign start_rel = pins_d_r.start_req && !pins.start_req
		&& (oem_r || !key_fit_r || pins.key_on);
	assign key_rise = pins.key_on && !pins_d_r.key_on;
	assign key_ok = oem_r || !key_fit_r || pins.key_on;

	always_comb
	begin
		armed_nxt = armed_r;
		if (!straps_ok_r)
			armed_nxt = 1'b0;
		else if (oem_r)
		begin
			// OEM arms with gate request and interlock
			if (pins.gate_req && pins.interlock)
				armed_nxt = 1'b1;
		end
		else if (!pins.interlock)
			armed_nxt = 1'b0;
		else if (start_rel || (key_fit_r && key_rise))
			armed_nxt = 1'b1;
		else if (!key_fit_r && !armed_r && !pins.start_req)
			armed_nxt = 1'b1;
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			armed_r <= 1'b0;
		else
			armed_r <= armed_nxt;
	end

	// ------------------------------------------------------------
	// Enable, gate and RF power
	// ------------------------------------------------------------
	// start request holds driver off
	assign enabled_c = armed_r && pins.interlock && !start_eff && key_ok
		&& !ovt_r && !sw_inhibit_r;
	assign gate_c = pins.gate_sw_open && pins.gate_req;
	assign rf_c = enabled_c && gate_c;

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			enabled_d_r <= 1'b0;
			gate_d_r <= 1'b0;
			ilk_d_r <= 1'b0;
			lase_ok_d_r <= 1'b0;
		end
		else
		begin
			enabled_d_r <= enabled_c;
			gate_d_r <= gate_c;
			ilk_d_r <= pins.interlock;
			lase_ok_d_r <= lase_ok;
		end
	end

	// ------------------------------------------------------------
	// Shared inhibit timer
	// ------------------------------------------------------------
	// enable rise starts inhibit
	assign restart = (enabled_c && !enabled_d_r) || (gate_c && !gate_d_r)
		|| (pins.interlock && !ilk_d_r);

	lesl_timer #(
		.CYCLES(INHIBIT_CYC)
	) u_timer (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_restart(restart),
		.o_busy(busy),
		.o_expired(expired)
	);

	assign lase_ok = rf_c && !busy && !restart;

	// ------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_lasing <= 1'b0;
			o_overheat <= 1'b0;
			o_enabled <= 1'b0;
			o_gate_open <= 1'b0;
			o_ilk_fault <= 1'b0;
			o_rf_power <= 1'b0;
			o_rf_pwm <= 1'b0;
		end
		else
		begin
			o_lasing <= lase_ok && pins.pwm;
			o_overheat <= ovt_r;
			o_enabled <= enabled_c;
			o_gate_open <= gate_c;
			o_ilk_fault <= !pins.interlock;
			o_rf_power <= rf_c;
			o_rf_pwm <= lase_ok && pins.pwm;
		end
	end

	assign stat.key_strap = key_fit_r;
	assign stat.oem_strap = oem_r;
	assign stat.armed = armed_r;
	assign stat.inhibit = busy;
	assign stat.rf_power = o_rf_power;
	assign stat.ilk_fault = o_ilk_fault;
	assign stat.gate_open = o_gate_open;
	assign stat.enabled = o_enabled;
	assign stat.overheat = o_overheat;
	assign stat.lasing = o_lasing;

	// ------------------------------------------------------------
	// Interrupt events
	// ------------------------------------------------------------
	always_comb
	begin
		events = '0;
		events[EV_OVERHEAT] = pins.over_temp && !ovt_r;
		events[EV_ILK_FAULT] = !pins.interlock && ilk_d_r;
		events[EV_ENABLED] = enabled_c && !enabled_d_r;
		events[EV_LASE_OK] = lase_ok && !lase_ok_d_r;
		events[EV_DISABLED] = !enabled_c && enabled_d_r;
	end

	assign irq_clr = (wr_go && i_avs_address == ADDR_IRQ_CLR) ?
		i_avs_writedata[EV_COUNT-1:0] : '0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			irq_stat_r <= '0;
		else
			irq_stat_r <= (irq_stat_r & ~irq_clr) | events;
	end

	assign o_irq = |(irq_stat_r & irq_en_r);

	// ------------------------------------------------------------
	// Avalon-MM slave: one wait state per access
	// ------------------------------------------------------------
	assign req = i_avs_read || i_avs_write;
	assign o_avs_waitrequest = req && !ack_r;
	assign wr_go = i_avs_write && ack_r;

	always_comb
	begin
		rd_nxt = READ_ZERO;
		case (i_avs_address)
			ADDR_CTRL: rd_nxt[CTRL_INHIBIT_BIT] = sw_inhibit_r;
			ADDR_STATUS: rd_nxt[STAT_W-1:0] = stat;
			ADDR_IRQ_STAT: rd_nxt[EV_COUNT-1:0] = irq_stat_r;
			ADDR_IRQ_EN: rd_nxt[EV_COUNT-1:0] = irq_en_r;
			default: rd_nxt = READ_ZERO;
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ack_r <= 1'b0;
			o_avs_readdata <= READ_ZERO;
		end
		else
		begin
			ack_r <= req && !ack_r;
			if (i_avs_read && !ack_r)
				o_avs_readdata <= rd_nxt;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			sw_inhibit_r <= CTRL_INHIBIT_RST;
			irq_en_r <= IRQ_EN_RST;
		end
		else if (wr_go)
		begin
			if (i_avs_address == ADDR_CTRL)
				sw_inhibit_r <= i_avs_writedata[CTRL_INHIBIT_BIT];
			if (i_avs_address == ADDR_IRQ_EN)
				irq_en_r <= i_avs_writedata[EV_COUNT-1:0];
		end
	end

endmodule

// ===== tb/lesl_monitor.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ns
module lesl_monitor
	import lesl_pkg::*;
#(
	parameter logic [31:0] INHIBIT_CYC = INHIBIT_CYCLES
)
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_interlock,
	input wire logic i_gate_req,
	input wire logic i_gate_sw_open,
	input wire logic i_start_req,
	input wire logic i_key_on,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	input wire logic o_lasing,
	input wire logic o_overheat,
	input wire logic o_enabled,
	input wire logic o_gate_open,
	input wire logic o_ilk_fault,
	input wire logic o_rf_power
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	logic [31:0] since_r;
	// Cycles since the last inhibit trigger
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			since_r <= 32'h0000_0000;
		else if ($rose(o_enabled) || $rose(o_gate_open) || $fell(o_ilk_fault))
			since_r <= 32'h0000_0000;
		else if (since_r != 32'hFFFF_FFFF)
			since_r <= since_r + 32'h0000_0001;
	end
	a_inhibit_window: assert property (o_lasing |-> since_r + 32'h0000_0003 >= INHIBIT_CYC)
		else $error("lasing inside inhibit interval");
	a_rf_needs_both: assert property (o_rf_power |->
		(o_enabled || $past(o_enabled)) && (o_gate_open || $past(o_gate_open)))
		else $error("rf power without enabled and gate");
	a_lase_needs_rf: assert property (o_lasing |-> o_rf_power || $past(o_rf_power))
		else $error("lasing without rf power");
	a_heat_latched: assert property ($fell(o_overheat) |-> 0)
		else $error("overheat status released");
	a_heat_disables: assert property (o_overheat [*3] |-> !o_enabled && !o_lasing)
		else $error("enabled during overheat");
	a_ilk_disables: assert property (o_ilk_fault [*3] |-> !o_enabled && !o_rf_power)
		else $error("enabled while interlock open");
	a_ilk_follows: assert property (!i_interlock [*8] |-> ##[0:4] o_ilk_fault)
		else $error("interlock fault not shown");
	a_gate_needs_both: assert property ((!i_gate_req || !i_gate_sw_open) [*8] |-> !o_gate_open)
		else $error("gate status without switch and request");
	a_start_blocks: assert property ((i_start_req && i_key_on) [*8] |-> !o_rf_power)
		else $error("rf power while start request held");
	a_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest)
		else $error("bus wait longer than one cycle");
	c_lase: cover property ($rose(o_lasing));
	c_ilk: cover property ($rose(o_ilk_fault));
	c_heat: cover property ($rose(o_overheat));
endmodule
bind lesl_top lesl_monitor #(.INHIBIT_CYC(INHIBIT_CYC)) lesl_monitor_inst (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_interlock(i_interlock),
	.i_gate_req(i_gate_req), .i_gate_sw_open(i_gate_sw_open), .i_start_req(i_start_req),
	.i_key_on(i_key_on), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_waitrequest(o_avs_waitrequest), .o_lasing(o_lasing), .o_overheat(o_overheat),
	.o_enabled(o_enabled), .o_gate_open(o_gate_open), .o_ilk_fault(o_ilk_fault),
	.o_rf_power(o_rf_power));

// ===== tb/lesl_plc_model.sv
// Controller model that drives the laser input pins
`timescale 1ns/1ns
module lesl_plc_model
	import lesl_pkg::*;
(
	input wire logic i_ref_clk,
	input wire lesl_pins_s i_cmd,
	input wire logic i_pulse_start,
	output lesl_pins_s o_pins
);
	logic [3:0] hold_r;
	always_ff @(posedge i_ref_clk)
	begin
		hold_r <= i_pulse_start ? 4'h8 : (hold_r != 4'h0 ? hold_r - 4'h1 : 4'h0);
		o_pins <= i_cmd;
		if (i_pulse_start || hold_r != 4'h0)
		begin
			o_pins.start_req <= 1'b1;
		end
	end
	initial hold_r = 4'h0;
endmodule

// ===== tb/test_laser_enable_status_logic.sv
// Self-checking bench of the laser enable sequencer
`timescale 1ns/1ns
module test_laser_enable_status_logic;
	import lesl_pkg::*;
	localparam logic [31:0] INH = 32'h0000_0032;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic pulse = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] rdat;
	logic [31:0] q;
	logic wt, las, ovh, ena, gto, ilk, rfp, rpw, irq;
	lesl_pins_s cmd = '0;
	lesl_pins_s pins;
	int n_errors = 0;
	int comparisons = 0;
	always #2 clk = ~clk;
	lesl_plc_model lesl_plc_model_inst (.i_ref_clk(clk), .i_cmd(cmd), .i_pulse_start(pulse),
		.o_pins(pins));
	lesl_top #(.INHIBIT_CYC(INH)) lesl_top_inst (.i_ref_clk(clk), .i_rst(rst),
		.i_interlock(pins.interlock), .i_gate_req(pins.gate_req), .i_start_req(pins.start_req),
		.i_gate_sw_open(pins.gate_sw_open), .i_key_on(pins.key_on),
		.i_over_temp(pins.over_temp), .i_pwm(pins.pwm), .i_oem_strap(pins.oem_strap),
		.i_key_strap(pins.key_strap), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wt), .o_lasing(las), .o_overheat(ovh), .o_enabled(ena),
		.o_gate_open(gto), .o_ilk_fault(ilk), .o_rf_power(rfp), .o_rf_pwm(rpw), .o_irq(irq));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic results;
		$display("comparisons=%0d errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		// Waitrequest and read data are taken at the rising edge itself
		@(posedge clk);
		while (wt !== 1'b0 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 20)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, wt, 1'b0);
			results();
		end
	endtask
	// Output pins and status register low bits together
	task automatic stat(input logic [5:0] e);
		chk({26'h0, rfp, ilk, gto, ena, ovh, las}, {26'h0, e});
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(q & 32'h0000_003F, {26'h0, e});
	endtask
	task automatic boot(input logic oem, input logic key);
		rst <= 1'b1;
		cmd.oem_strap <= oem;
		cmd.key_strap <= key;
		tick(5);
		rst <= 1'b0;
		tick(12);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		boot(1'b0, 1'b0);
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk(q, READ_ZERO);
		bus(1'b0, ADDR_IRQ_EN, 32'h0);
		chk(q, READ_ZERO);
		bus(1'b1, ADDR_IRQ_EN, 32'h0000_001F);
		bus(1'b0, ADDR_IRQ_EN, 32'h0);
		chk(q, 32'h0000_001F);
		bus(1'b1, ADDR_IRQ_EN, 32'h0);
		bus(1'b0, 8'h20, 32'h0);
		chk(q, READ_ZERO);
		stat(6'h10);
	endtask
	task automatic t_run;
		cmd.interlock <= 1'b1;
		cmd.gate_req <= 1'b1;
		cmd.gate_sw_open <= 1'b1;
		cmd.pwm <= 1'b1;
		tick(10);
		stat(6'h2C);
		tick(INH - 30);
		chk(las, 1'b0);
		tick(40);
		stat(6'h2D);
		chk(rpw, 1'b1);
		bus(1'b1, ADDR_IRQ_EN, 32'h0000_0008);
		tick(1);
		chk(irq, 1'b1);
		bus(1'b1, ADDR_IRQ_CLR, 32'h0000_0008);
		tick(1);
		chk(irq, 1'b0);
		bus(1'b1, ADDR_IRQ_EN, 32'h0);
		cmd.pwm <= 1'b0;
		tick(10);
		chk(las, 1'b0);
		chk(rpw, 1'b0);
	endtask
	task automatic t_gate;
		cmd.gate_req <= 1'b0;
		tick(10);
		stat(6'h04);
		cmd.gate_req <= 1'b1;
		cmd.pwm <= 1'b1;
		tick(INH - 20);
		chk(las, 1'b0);
		tick(40);
		chk(las, 1'b1);
	endtask
	task automatic t_ilk;
		cmd.interlock <= 1'b0;
		tick(10);
		stat(6'h18);
		cmd.interlock <= 1'b1;
		tick(INH - 20);
		chk({ilk, las}, 2'b00);
		tick(40);
		chk(las, 1'b1);
		cmd.pwm <= 1'b0;
	endtask
	task automatic t_start;
		cmd.start_req <= 1'b1;
		tick(10);
		stat(6'h08);
		cmd.start_req <= 1'b0;
		tick(10);
		stat(6'h2C);
		bus(1'b1, ADDR_CTRL, 32'h0000_0001);
		tick(3);
		chk(ena, 1'b0);
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk(q, 32'h0000_0001);
		bus(1'b1, ADDR_CTRL, 32'h0);
	endtask
	task automatic t_heat;
		cmd.over_temp <= 1'b1;
		tick(10);
		cmd.over_temp <= 1'b0;
		tick(10);
		stat(6'h0A);
	endtask
	task automatic t_key;
		cmd.key_on <= 1'b0;
		boot(1'b0, 1'b1);
		pulse <= 1'b1;
		tick(1);
		pulse <= 1'b0;
		tick(20);
		stat(6'h08);
		cmd.key_on <= 1'b1;
		tick(10);
		chk(ena, 1'b1);
		cmd.interlock <= 1'b0;
		tick(10);
		cmd.interlock <= 1'b1;
		tick(10);
		stat(6'h08);
		pulse <= 1'b1;
		tick(1);
		pulse <= 1'b0;
		tick(20);
		stat(6'h2C);
	endtask
	task automatic t_oem;
		boot(1'b1, 1'b0);
		tick(5);
		stat(6'h2C);
		cmd.interlock <= 1'b0;
		tick(10);
		stat(6'h18);
		cmd.interlock <= 1'b1;
		tick(10);
		stat(6'h2C);
		cmd.start_req <= 1'b1;
		tick(10);
		chk(rfp, 1'b0);
	endtask
	initial
	begin
		cmd.key_on = 1'b1;
		t_regs();
		t_run();
		t_gate();
		t_ilk();
		t_start();
		t_heat();
		t_key();
		t_oem();
		results();
	end
endmodule
